// File: design/tcmo_timer.sv
// Timer compare output stage with normal, clear-on-match and fast PWM
`timescale 1ns/1ns

// Behaviour
// - Nonzero action select overrides port output value
// - Pin direction bit alone gates the driver
// - Override ignores waveform mode
// - Compare output register presettable before driver enable
// - Action zero leaves compare output unchanged
// - New action applies from next match
// - Force strobe applies action in non-PWM
// - Only waveform mode steers counting
// - Normal mode increments and wraps at max
// - Normal overflow flag set when count zeroes
// - Count writable any time in normal
// - Clear-on-match clears count at compare A
// - Unbuffered compare A may miss, wrap first
// - Clear-on-match action one toggles output
// - Clear-on-match overflow at max to zero
// - Fast PWM counts zero to top, restarts
// - Fast PWM clears on tick after top
// - Fast PWM two clears on match, sets bottom
// - Fast PWM overflow flag set at top
// - Fast PWM extreme compare values special
// - Fast PWM action one toggles on match in TCMO_FPWM_A only
// - Fast PWM compare value double buffered
// - Match sets match flag next tick
// - Count write blocks next tick match
// - Count write beats clear and count
module tcmo_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_tick,
  output logic             compare_pin_out,
  output logic             compare_pin_oe
);

  logic                    wr_en;
  logic                    rd_en;
  logic                    tick_s1_ff;
  logic                    tick_s2_ff;
  logic                    tick;
  logic [2:0]              waveform_mode_select_ff;
  logic [1:0]              output_action_select_a_ff;
  logic                    compare_pin_direction_ff;
  logic                    port_value_ff;
  logic [7:0]              count_value_ff;
  logic [7:0]              nxt_count;
  logic [7:0]              compare_value_a_ff;
  logic [7:0]              compare_buf_ff;
  logic                    overflow_flag_ff;
  logic                    match_flag_a_ff;
  logic                    compare_output_a_ff;
  logic                    block_ff;
  logic                    cnt_wr;
  logic                    force_wr;
  logic                    match;
  logic                    is_pwm;
  logic                    at_top;
  logic [7:0]              top;
  tcmo_pkg::tcmo_pin_t     pin_ff;

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign cnt_wr = wr_en && (paddr == tcmo_pkg::TCMO_OFF_COUNT);
  assign force_wr = wr_en && (paddr == tcmo_pkg::TCMO_OFF_STROBE) &&
                    pwdata[tcmo_pkg::TCMO_STB_FORCE_BIT];

  // Tick arrives from a prescaler outside this domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_s1_ff <= 1'b0;
      tick_s2_ff <= 1'b0;
    end else begin
      tick_s1_ff <= timer_tick;
      tick_s2_ff <= tick_s1_ff;
    end
  end
  assign tick = tick_s2_ff;

  function automatic logic mode_is_pwm(input logic [2:0] m);
    mode_is_pwm = (m == tcmo_pkg::TCMO_FPWM) || (m == tcmo_pkg::TCMO_FPWM_A);
  endfunction

  // Compare value in use; PWM loads it from the buffered copy at top
  assign is_pwm = mode_is_pwm(waveform_mode_select_ff);
  assign top    = (waveform_mode_select_ff == tcmo_pkg::TCMO_FPWM) ?
                  tcmo_pkg::TCMO_MAX : compare_value_a_ff;
  assign match  = (count_value_ff == compare_value_a_ff) && !block_ff;

  always_comb begin
    nxt_count = count_value_ff + 8'h01;
    at_top = 1'b0;
    unique case (waveform_mode_select_ff)
      tcmo_pkg::TCMO_CLR_MATCH: begin
        // Missed match simply wraps through max
        if (count_value_ff == compare_value_a_ff) begin
          nxt_count = tcmo_pkg::TCMO_BOTTOM;
        end
      end
      tcmo_pkg::TCMO_FPWM, tcmo_pkg::TCMO_FPWM_A: begin
        at_top = (count_value_ff == top);
        if (at_top) begin
          nxt_count = tcmo_pkg::TCMO_BOTTOM;
        end
      end
      default: begin
        nxt_count = count_value_ff + 8'h01;
      end
    endcase
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_mode_select_ff   <= tcmo_pkg::TCMO_RST_WGM;
      output_action_select_a_ff <= tcmo_pkg::TCMO_RST_COM;
      compare_pin_direction_ff  <= 1'b0;
      port_value_ff             <= 1'b0;
    end else if (wr_en && (paddr == tcmo_pkg::TCMO_OFF_CTRL)) begin
      waveform_mode_select_ff   <=
        pwdata[tcmo_pkg::TCMO_CTRL_WGM_LSB +: 3];
      output_action_select_a_ff <=
        pwdata[tcmo_pkg::TCMO_CTRL_COM_LSB +: 2];
      compare_pin_direction_ff  <= pwdata[tcmo_pkg::TCMO_CTRL_DIR_BIT];
      port_value_ff             <= pwdata[tcmo_pkg::TCMO_CTRL_PORT_BIT];
    end
  end

  // Counter; software write beats hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_ff <= 8'h00;
    end else if (cnt_wr) begin
      count_value_ff <= pwdata[7:0];
    end else if (tick) begin
      count_value_ff <= nxt_count;
    end
  end

  // Match block lasts through the next tick, timer running or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_ff <= 1'b0;
    end else if (cnt_wr) begin
      block_ff <= 1'b1;
    end else if (tick) begin
      block_ff <= 1'b0;
    end
  end

  // Compare buffer; PWM loads the active copy at top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_buf_ff     <= 8'h00;
      compare_value_a_ff <= 8'h00;
    end else begin
      if (wr_en && (paddr == tcmo_pkg::TCMO_OFF_CMPA)) begin
        compare_buf_ff <= pwdata[7:0];
      end
      if (wr_en && (paddr == tcmo_pkg::TCMO_OFF_CMPA) && !is_pwm) begin
        compare_value_a_ff <= pwdata[7:0];
      end else if (is_pwm && tick && at_top) begin
        compare_value_a_ff <= compare_buf_ff;
      end
    end
  end

  // Flags: set wins over a software clear-by-one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_ff <= 1'b0;
      match_flag_a_ff  <= 1'b0;
    end else begin
      if (tick && !cnt_wr && (is_pwm ? at_top :
          count_value_ff == tcmo_pkg::TCMO_MAX)) begin
        overflow_flag_ff <= 1'b1;
      end else if (wr_en && (paddr == tcmo_pkg::TCMO_OFF_FLAGS) &&
                   pwdata[tcmo_pkg::TCMO_FLG_OVF_BIT]) begin
        overflow_flag_ff <= 1'b0;
      end
      if (tick && match) begin
        match_flag_a_ff <= 1'b1;
      end else if (wr_en && (paddr == tcmo_pkg::TCMO_OFF_FLAGS) &&
                   pwdata[tcmo_pkg::TCMO_FLG_MATCH_BIT]) begin
        match_flag_a_ff <= 1'b0;
      end
    end
  end

  // Compare output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_a_ff <= 1'b0;
    end else if (force_wr && !is_pwm) begin
      unique case (output_action_select_a_ff)
        tcmo_pkg::TCMO_ACT_TOGGLE: begin
          compare_output_a_ff <= !compare_output_a_ff;
        end
        tcmo_pkg::TCMO_ACT_CLEAR:  compare_output_a_ff <= 1'b0;
        tcmo_pkg::TCMO_ACT_SET:    compare_output_a_ff <= 1'b1;
        tcmo_pkg::TCMO_ACT_NONE:   compare_output_a_ff <= compare_output_a_ff;
      endcase
    end else if (tick && is_pwm) begin
      // With action 2 or 3, match at top is ignored; bottom action alone decides
      if (output_action_select_a_ff[1] && at_top) begin
        compare_output_a_ff <= !output_action_select_a_ff[0];
      end else if (output_action_select_a_ff[1] && match) begin
        compare_output_a_ff <= output_action_select_a_ff[0];
      end else if (output_action_select_a_ff ==
                   tcmo_pkg::TCMO_ACT_TOGGLE && match &&
                   waveform_mode_select_ff[2]) begin
        compare_output_a_ff <= !compare_output_a_ff;
      end
    end else if (tick && match) begin
      unique case (output_action_select_a_ff)
        tcmo_pkg::TCMO_ACT_TOGGLE: begin
          compare_output_a_ff <= !compare_output_a_ff;
        end
        tcmo_pkg::TCMO_ACT_CLEAR:  compare_output_a_ff <= 1'b0;
        tcmo_pkg::TCMO_ACT_SET:    compare_output_a_ff <= 1'b1;
        tcmo_pkg::TCMO_ACT_NONE: begin
          compare_output_a_ff <= compare_output_a_ff;
        end
      endcase
    end
  end

  // Pin: override by action select only, driver by direction only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_ff <= '0;
    end else begin
      pin_ff.pin_out <= (output_action_select_a_ff != 2'b00) ?
                        compare_output_a_ff : port_value_ff;
      pin_ff.pin_oe  <= compare_pin_direction_ff;
    end
  end
  assign compare_pin_out = pin_ff.pin_out;
  assign compare_pin_oe  = pin_ff.pin_oe;

  // APB: zero wait states, unmapped reads zero with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {
        tcmo_pkg::TCMO_OFF_CTRL, tcmo_pkg::TCMO_OFF_COUNT,
        tcmo_pkg::TCMO_OFF_CMPA, tcmo_pkg::TCMO_OFF_FLAGS,
        tcmo_pkg::TCMO_OFF_STROBE, tcmo_pkg::TCMO_OFF_STATUS});
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          tcmo_pkg::TCMO_OFF_CTRL: prdata <= {22'h0, compare_output_a_ff,
            tick, port_value_ff, compare_pin_direction_ff,
            output_action_select_a_ff, 1'b0, waveform_mode_select_ff};
          tcmo_pkg::TCMO_OFF_COUNT:  prdata <= {24'h0, count_value_ff};
          tcmo_pkg::TCMO_OFF_CMPA:   prdata <= {24'h0, compare_buf_ff};
          tcmo_pkg::TCMO_OFF_FLAGS:  prdata <= {30'h0, match_flag_a_ff,
                                               overflow_flag_ff};
          tcmo_pkg::TCMO_OFF_STATUS: prdata <= {24'h0, compare_value_a_ff};
          default:                   prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Unused read strobe kept for clarity of decode
  logic unused_rd;
  assign unused_rd = rd_en;

  // Steps used by the checks; s_pwm_top is shared by three
  sequence s_pwm_top;
    tick && !cnt_wr && is_pwm && at_top;
  endsequence
  sequence s_clr_hit;
    tick && !cnt_wr &&
    waveform_mode_select_ff == tcmo_pkg::TCMO_CLR_MATCH &&
    count_value_ff == compare_value_a_ff;
  endsequence

  a_clear_match: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_clr_hit |=> count_value_ff == 8'h00)
    else $error("clear-on-match did not clear");
  a_normal_wrap: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && !cnt_wr && waveform_mode_select_ff == tcmo_pkg::TCMO_NORMAL)
    |=> count_value_ff == $past(count_value_ff) + 8'h01)
    else $error("normal count wrong");
  a_ovf_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && !cnt_wr && !is_pwm && count_value_ff == 8'hff)
    |=> overflow_flag_ff)
    else $error("overflow not set");
  a_clr_ovf: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && !cnt_wr && count_value_ff == 8'hff &&
     waveform_mode_select_ff == tcmo_pkg::TCMO_CLR_MATCH) |=> overflow_flag_ff)
    else $error("clear-on-match overflow not set");
  a_match_flag: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && match) |=> match_flag_a_ff)
    else $error("match flag not set");
  a_cnt_prio: assert property (@(posedge pclk)
    disable iff (!presetn)
    cnt_wr |=> count_value_ff == $past(pwdata[7:0]))
    else $error("count write lost");
  // A match set in the very tick of the write is legal, so look one later
  a_write_block: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && block_ff && !match_flag_a_ff &&
     count_value_ff == compare_value_a_ff) |=> !match_flag_a_ff)
    else $error("match not blocked");
  a_pin_dir: assert property (@(posedge pclk)
    disable iff (!presetn)
    1'b1 |=> compare_pin_oe == $past(compare_pin_direction_ff))
    else $error("pin enable wrong");
  a_pin_override: assert property (@(posedge pclk)
    disable iff (!presetn)
    (output_action_select_a_ff != 2'b00)
    |=> compare_pin_out == $past(compare_output_a_ff))
    else $error("pin not overridden");
  a_act_none: assert property (@(posedge pclk)
    disable iff (!presetn)
    (output_action_select_a_ff == 2'b00 && !force_wr)
    |=> $stable(compare_output_a_ff))
    else $error("output moved with no action");
  a_force_set: assert property (@(posedge pclk)
    disable iff (!presetn)
    (force_wr && !is_pwm && output_action_select_a_ff == 2'b11)
    |=> compare_output_a_ff)
    else $error("force did not set output");
  a_match_toggle: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && match && !force_wr && output_action_select_a_ff == 2'b01 &&
     waveform_mode_select_ff == tcmo_pkg::TCMO_CLR_MATCH)
    |=> compare_output_a_ff != $past(compare_output_a_ff))
    else $error("output did not toggle");
  a_pwm_bottom: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && is_pwm && at_top && output_action_select_a_ff == 2'b10)
    |=> compare_output_a_ff)
    else $error("pwm not set at bottom");
  a_pwm_clear: assert property (@(posedge pclk)
    disable iff (!presetn)
    (tick && is_pwm && match && !at_top &&
     output_action_select_a_ff == 2'b10) |=> !compare_output_a_ff)
    else $error("pwm not cleared on match");
  a_pwm_wrap: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_pwm_top |=> count_value_ff == 8'h00)
    else $error("pwm did not restart");
  a_pwm_ovf: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_pwm_top |=> overflow_flag_ff)
    else $error("pwm overflow not set");
  // Buffer copy moves only at top, so no odd-length pulse appears
  a_buf_load: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_pwm_top |=> compare_value_a_ff == $past(compare_buf_ff))
    else $error("compare buffer not loaded");
  a_count_hold: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!tick && !cnt_wr) |=> $stable(count_value_ff))
    else $error("count moved without tick");
  a_apb_ready: assert property (@(posedge pclk)
    disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("no ready in access phase");

endmodule

// File: pkg/tcmo_pkg.sv
// Package for the timer compare output block: offsets, fields, modes
package tcmo_pkg;

  localparam logic [7:0] TCMO_OFF_CTRL    = 8'h00;
  localparam logic [7:0] TCMO_OFF_COUNT   = 8'h04;
  localparam logic [7:0] TCMO_OFF_CMPA    = 8'h08;
  localparam logic [7:0] TCMO_OFF_FLAGS   = 8'h0c;
  localparam logic [7:0] TCMO_OFF_STROBE  = 8'h10;
  localparam logic [7:0] TCMO_OFF_STATUS  = 8'h14;

  // Control register field positions
  localparam int TCMO_CTRL_WGM_LSB  = 0;
  localparam int TCMO_CTRL_COM_LSB  = 4;
  localparam int TCMO_CTRL_DIR_BIT  = 6;
  localparam int TCMO_CTRL_PORT_BIT = 7;
  localparam int TCMO_CTRL_TICK_BIT = 8;
  localparam int TCMO_CTRL_OC_BIT   = 9;
  // Flag register fields
  localparam int TCMO_FLG_OVF_BIT   = 0;
  localparam int TCMO_FLG_MATCH_BIT = 1;
  // Strobe register field
  localparam int TCMO_STB_FORCE_BIT = 0;

  localparam logic [7:0] TCMO_MAX    = 8'hff;
  localparam logic [7:0] TCMO_BOTTOM = 8'h00;
  localparam logic [2:0] TCMO_RST_WGM = 3'h0;
  localparam logic [1:0] TCMO_RST_COM = 2'h0;

  typedef enum logic [2:0] {
    TCMO_NORMAL   = 3'b000,
    TCMO_PCPWM    = 3'b001,
    TCMO_CLR_MATCH = 3'b010,
    TCMO_FPWM     = 3'b011,
    TCMO_RSV4     = 3'b100,
    TCMO_PCPWM_A  = 3'b101,
    TCMO_RSV6     = 3'b110,
    TCMO_FPWM_A   = 3'b111
  } tcmo_mode_t;

  typedef enum logic [1:0] {
    TCMO_ACT_NONE   = 2'b00,
    TCMO_ACT_TOGGLE = 2'b01,
    TCMO_ACT_CLEAR  = 2'b10,
    TCMO_ACT_SET    = 2'b11
  } tcmo_act_t;

  // Pin outputs travel together
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } tcmo_pin_t;

endpackage

// File: tb/tcmo_load.sv
// External load hanging on the compare pin
`timescale 1ns/1ns
module tcmo_load (
  input  wire tcmo_pkg::tcmo_pin_t pin,
  output logic                     level
);
  // Pull-down: a released pin reads low, never its last driven value
  assign level = pin.pin_oe ? pin.pin_out : 1'b0;
endmodule

// File: tb/tb.sv
// Self-checking bench for the timer compare output block
`timescale 1ns/1ns
module tb;
  localparam logic [7:0]  A_CTL = tcmo_pkg::TCMO_OFF_CTRL;
  localparam logic [7:0]  A_CNT = tcmo_pkg::TCMO_OFF_COUNT;
  localparam logic [7:0]  A_CMP = tcmo_pkg::TCMO_OFF_CMPA;
  localparam logic [7:0]  A_FLG = tcmo_pkg::TCMO_OFF_FLAGS;
  localparam logic [7:0]  A_STB = tcmo_pkg::TCMO_OFF_STROBE;
  localparam logic [7:0]  A_STS = tcmo_pkg::TCMO_OFF_STATUS;
  localparam logic [2:0]  MD_N  = tcmo_pkg::TCMO_NORMAL;
  localparam logic [2:0]  MD_C  = tcmo_pkg::TCMO_CLR_MATCH;
  localparam logic [2:0]  MD_F  = tcmo_pkg::TCMO_FPWM;
  localparam logic [2:0]  MD_A  = tcmo_pkg::TCMO_FPWM_A;
  // Masks also cover the error bit, so a refused read never slips by; writes are not checked
  localparam logic [32:0] M_ALL = 33'h1_ffff_ffff;
  localparam logic [32:0] M_OC  = 33'h1_0000_0200;
  localparam logic [32:0] M_CNT = 33'h1_0000_00ff;
  localparam logic [32:0] M_FLG = 33'h1_0000_0003;
  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic                timer_tick;
  logic [7:0]          paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                pin_lvl;
  tcmo_pkg::tcmo_pin_t pin;
  logic [65:0]         notes[$];
  logic [65:0]         nt;
  logic [31:0]         v;
  logic [7:0]          cnt;
  int                  n_fail;
  int                  n_checks;
  int                  seed;
  int                  i;

  tcmo_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .compare_pin_out(pin.pin_out),
    .compare_pin_oe(pin.pin_oe));
  tcmo_load load (.pin(pin), .level(pin_lvl));

  always #5 pclk = ~pclk;

  function automatic logic [31:0] ctrl(input logic [2:0] md,
    input logic [1:0] ac, input logic dr, input logic pv);
    ctrl = {24'h0, pv, dr, ac, 1'b0, md};
  endfunction

  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Held until pready is seen high; one idle edge keeps drives apart
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) notes.push_back({m, e});
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
    input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m);
  endtask

  // Gaps leave room for the two-flop tick synchroniser
  task automatic tick(input int n);
    repeat (n) begin
      timer_tick <= 1'b1;
      @(posedge pclk);
      timer_tick <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  task automatic chkpin(input logic e);
    repeat (3) @(posedge pclk);
    n_checks++;
    if (pin_lvl !== e) begin
      n_fail++;
      $display("[ERR] t=%0t pin=%h exp=%h", $time, pin_lvl, e);
    end
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      nt = notes.pop_front();
      n_checks++;
      if ((({pslverr, prdata} ^ nt[32:0]) & nt[65:33]) !== 33'h0) begin
        n_fail++;
        $display("[ERR] t=%0t got=%h exp=%h", $time,
          {pslverr, prdata} & nt[65:33], nt[32:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    final_report();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, timer_tick} = 6'h0;
    {paddr, pwdata, n_fail, n_checks, seed} = {8'h0, 32'h0, 64'h0, 32'd88};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTL, 33'h0, M_ALL);
    rd(A_CNT, 33'h0, M_ALL);
    rd(8'h40, 33'h1_0000_0000, M_ALL);
    chkpin(1'b0);
    // Output prepared while the driver is still off
    wr(A_CTL, ctrl(MD_N, 2'h3, 1'b0, 1'b0));
    wr(A_STB, 32'h1);
    rd(A_CTL, 33'h200, M_OC);
    chkpin(1'b0);
    wr(A_CTL, ctrl(MD_N, 2'h0, 1'b1, 1'b1));
    chkpin(1'b1);
    wr(A_CTL, ctrl(MD_N, 2'h3, 1'b1, 1'b0));
    chkpin(1'b1);
    wr(A_CTL, ctrl(MD_N, 2'h1, 1'b1, 1'b0));
    wr(A_STB, 32'h1);
    chkpin(1'b0);
    wr(A_CTL, ctrl(MD_F, 2'h3, 1'b1, 1'b1));
    wr(A_STB, 32'h1);
    chkpin(1'b0);
    wr(A_CTL, ctrl(MD_N, 2'h0, 1'b1, 1'b0));
    wr(A_CNT, 32'hfe);
    tick(2);
    rd(A_CNT, 33'h0, M_CNT);
    rd(A_FLG, 33'h1, 33'h1_0000_0001);
    wr(A_FLG, 32'h3);
    rd(A_FLG, 33'h0, M_FLG);
    wr(A_CMP, 32'h5);
    wr(A_CNT, 32'h5);
    tick(1);
    rd(A_FLG, 33'h0, M_FLG);
    wr(A_CNT, 32'h4);
    tick(3);
    rd(A_CNT, 33'h7, M_CNT);
    rd(A_FLG, 33'h2, M_FLG);
    wr(A_FLG, 32'h3);
    wr(A_CTL, ctrl(MD_C, 2'h1, 1'b1, 1'b0));
    wr(A_CMP, 32'h3);
    wr(A_CNT, 32'h0);
    tick(5);
    rd(A_CNT, 33'h1, M_CNT);
    rd(A_FLG, 33'h2, M_FLG);
    rd(A_CTL, 33'h200, M_OC);
    // Count set above the compare value must run round the top first
    wr(A_FLG, 32'h3);
    wr(A_CNT, 32'h5);
    tick(251);
    rd(A_CNT, 33'h0, M_CNT);
    rd(A_FLG, 33'h1, M_FLG);
    for (i = 2; i < 4; i++) begin
      wr(A_CTL, ctrl(MD_F, i[1:0], 1'b1, 1'b0));
      wr(A_CMP, i * 32'h40);
      rd(A_STS, (i == 2) ? 33'h3 : 33'h80, M_CNT);
      wr(A_FLG, 32'h3);
      wr(A_CNT, 32'hfe);
      tick(2);
      rd(A_CNT, 33'h0, M_CNT);
      rd(A_FLG, 33'h1, 33'h1_0000_0001);
      rd(A_STS, i * 33'h40, M_CNT);
      tick(16);
      rd(A_CTL, (i == 2) ? 33'h200 : 33'h0, M_OC);
      tick(i * 64);
      rd(A_CTL, (i == 3) ? 33'h200 : 33'h0, M_OC);
    end
    wr(A_CMP, 32'h9);
    wr(A_CNT, 32'hfe);
    tick(2);
    wr(A_CTL, ctrl(MD_A, 2'h1, 1'b1, 1'b0));
    wr(A_CNT, 32'h0);
    tick(12);
    rd(A_CNT, 33'h2, M_CNT);
    rd(A_CTL, 33'h200, M_OC);
    wr(A_CTL, ctrl(MD_N, 2'h0, 1'b1, 1'b0));
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(A_CNT, {24'h0, v[7:0]});
      tick(v[9:8] + 1);
      cnt = v[7:0] + {6'h0, v[9:8]} + 8'h1;
      rd(A_CNT, {25'h0, cnt}, M_CNT);
    end
    final_report();
  end
endmodule
